// File: bench/mac_arm_src.sv
// Behavioural sync source that drives the arming input of the block.
// Assumes fire_i is a one-cycle request synchronous to mclk_i.
`timescale 1ns/100ps
`default_nettype none
module mac_arm_src #(
   parameter int unsigned WIDTH = 3
) (
   input  wire logic       mclk_i,
   input  wire logic       fire_i,
   input  wire logic       fall_i,
   input  wire logic [3:0] lag_i,
   output logic            arm_o
);
   logic [4:0] cnt_q = 5'h00;
   // A request during a pulse is dropped, as a real sync line cannot
   // give two edges at once.
   always @(posedge mclk_i) begin
      if (fire_i && cnt_q == 5'h00) begin
         cnt_q <= {1'b0, lag_i} + 5'(WIDTH);
      end else if (cnt_q != 5'h00) begin
         cnt_q <= cnt_q - 5'h01;
      end
   end
   // The bench also triggers once before armed_o, to check that a trigger without an arming edge starts nothing.
   assign arm_o = fall_i ^ (cnt_q != 5'h00 && cnt_q <= 5'(WIDTH));
endmodule
`default_nettype wire

// File: bench/mac_top_tb_top.sv
// Self-checking bench for the measurement arming control top.
// Assumes short hold, processing and spacing counts set as parameters.
`timescale 1ns/100ps
`default_nettype none
module mac_top_tb_top;
   localparam int HOLD  = 20;
   localparam int PROC  = 10;
   localparam int SPACE = 18;
   localparam int STEP  = 4;
   localparam logic [31:0] RUN = 32'h1 << mac_pkg::CTL_RUN;
   localparam logic [31:0] AST = 32'h1 << mac_pkg::CTL_ASTART;
   localparam logic [31:0] ASP = 32'h1 << mac_pkg::CTL_ASTOP;
   localparam logic [31:0] SGL = 32'h1 << mac_pkg::CTL_SINGLE;
   localparam logic [31:0] DLY = 32'h1 << mac_pkg::CTL_DLY_EN;
   localparam logic [31:0] MIS = 32'h1 << mac_pkg::STS_MISSED;
   localparam logic [31:0] FAL = (32'h1 << mac_pkg::CTL_AS_FAL) |
                                 (32'h1 << mac_pkg::CTL_AP_FAL);
   logic                   mclk = 1'b0;
   logic                   rstn = 1'b0;
   logic                   psel = 1'b0;
   logic                   penable = 1'b0;
   logic                   pwrite = 1'b0;
   logic [mac_pkg::AW-1:0] paddr = '0;
   logic [31:0]            pwdata = 32'h0;
   logic [31:0]            prdata;
   logic                   pready, pslverr, arm, gate, mstart, mend, armed;
   logic                   trig = 1'b0;
   logic                   stop = 1'b0;
   logic                   fire = 1'b0;
   logic                   afall = 1'b0;
   logic                   trig_run = 1'b0;
   logic                   trig_gen = 1'b0;
   logic [3:0]             lag = 4'h0;
   int                     n_fail = 0;
   int                     n_checks = 0;

   always #2 mclk = ~mclk;
   always @(posedge mclk) begin
      trig_gen <= trig_run ? ~trig_gen : 1'b0;
   end

   mac_top #(.HOLD_MIN_ST(HOLD), .PROC_ST(PROC), .SPACE_ST(SPACE),
      .STEP_CYC(STEP)) i_mac_top (
      .mclk_i(mclk), .rstn_i(rstn), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
      .arm_i(arm), .trig_i(trig | trig_gen), .stop_i(stop),
      .meas_gate_o(gate), .meas_start_o(mstart), .meas_end_o(mend),
      .armed_o(armed));
   mac_arm_src i_mac_arm_src (
      .mclk_i(mclk), .fire_i(fire), .fall_i(afall), .lag_i(lag),
      .arm_o(arm));

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic chk_rng(input int n, input int lo, input int hi);
      chk(32'(n), (n >= lo && n <= hi) ? 32'(n) : 32'(lo));
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic e);
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      // The wait ends when pready is seen high, or else by the bench watchdog.
      do begin
         @(posedge mclk);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        e;
      apb(1'b1, a, d, q, e);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] x,
      input logic xe);
      logic [31:0] q;
      logic        e;
      apb(1'b0, a, 32'h0, q, e);
      chk(q, x);
      chk({31'h0, e}, {31'h0, xe});
   endtask
   function automatic logic sig(input int w);
      case (w)
         0: return mstart;
         1: return mend;
         2: return armed;
         default: return gate;
      endcase
   endfunction
   task automatic wait_on(input int w, input int lim, output int n);
      n = 0;
      while (sig(w) !== 1'b1 && n < lim) begin
         @(posedge mclk);
         n++;
      end
   endtask
   // Kinds: 0 trigger, 1 stop trigger, 2 arming request to the source.
   task automatic pulse(input int w);
      @(posedge mclk);
      if (w == 0) trig <= 1'b1;
      else if (w == 1) stop <= 1'b1;
      else fire <= 1'b1;
      @(posedge mclk);
      trig <= 1'b0;
      stop <= 1'b0;
      fire <= 1'b0;
   endtask

   initial begin
      #200000;
      n_fail++;
      tally_and_finish;
   end

   initial begin
      int n, i, m, ex;
      logic [31:0] c0;
      logic        e;
      repeat (3) @(posedge mclk);
      rstn <= 1'b1;
      repeat (4) @(posedge mclk);
      rd(mac_pkg::OFF_CTRL, 32'h0, 1'b0);
      rd(mac_pkg::OFF_MTIME, 32'h2710, 1'b0);
      rd(mac_pkg::OFF_DELAY, 32'h2, 1'b0);
      rd(mac_pkg::OFF_STATUS, 32'h0, 1'b0);
      rd(mac_pkg::OFF_COUNT, 32'h0, 1'b0);
      rd(8'h14, 32'h0, 1'b1);
      // Spacing is the larger of measure plus processing and the floor.
      for (i = 0; i < 2; i++) begin
         m = i ? 12 : 3;
         ex = (m + PROC > SPACE) ? m + PROC : SPACE;
         wr(mac_pkg::OFF_MTIME, 32'(m));
         wr(mac_pkg::OFF_CTRL, RUN);
         trig_run <= 1'b1;
         wait_on(0, 400, n);
         @(posedge mclk);
         wait_on(0, 600, n);
         chk_rng(n + 1, (ex - 2) * STEP, (ex + 2) * STEP);
         trig_run <= 1'b0;
         wr(mac_pkg::OFF_CTRL, 32'h0);
         // Starts are spaced in every mode, so let the floor run out.
         repeat (SPACE * STEP) @(posedge mclk);
      end
      for (i = 0; i < 2; i++) begin
         m = i ? 25 : 3;
         ex = (m > HOLD) ? m : HOLD;
         wr(mac_pkg::OFF_MTIME, 32'(m));
         wr(mac_pkg::OFF_CTRL, RUN | SGL);
         wait_on(2, 50, n);
         chk_rng(n, 0, 40);
         pulse(0);
         wait_on(0, 8, n);
         chk_rng(n, 0, 4);
         repeat (100) @(posedge mclk);
         chk({31'h0, gate}, 32'h1);
         pulse(1);
         wait_on(1, 8, n);
         chk_rng(n, 0, 4);
         @(posedge mclk);
         wait_on(2, 400, n);
         chk_rng(n, (ex - 1) * STEP, (ex + 1) * STEP + 4);
         wr(mac_pkg::OFF_CTRL, 32'h0);
      end
      wr(mac_pkg::OFF_MTIME, 32'h3);
      wr(mac_pkg::OFF_CTRL, RUN | AST | SGL);
      apb(1'b0, mac_pkg::OFF_COUNT, 32'h0, c0, e);
      pulse(0);
      wait_on(3, 10, n);
      chk(32'(n), 32'd10);
      pulse(2);
      wait_on(2, 12, n);
      chk_rng(n, 0, 8);
      repeat (5) @(posedge mclk);
      chk({31'h0, gate}, 32'h0);
      pulse(0);
      wait_on(0, 8, n);
      chk_rng(n, 0, 4);
      lag <= 4'h4;
      pulse(2);
      repeat (30) @(posedge mclk);
      lag <= 4'h0;
      pulse(1);
      wait_on(1, 8, n);
      // A third arming edge lands inside the hold period.
      pulse(2);
      repeat (HOLD * STEP + 20) @(posedge mclk);
      chk({31'h0, armed}, 32'h0);
      rd(mac_pkg::OFF_STATUS, MIS, 1'b0);
      rd(mac_pkg::OFF_COUNT, c0 + 32'h1, 1'b0);
      wr(mac_pkg::OFF_STATUS, MIS);
      rd(mac_pkg::OFF_STATUS, 32'h0, 1'b0);
      // A zero delay is raised to the shortest legal delay.
      for (i = 0; i < 2; i++) begin
         ex = i ? 2 : 5;
         wr(mac_pkg::OFF_DELAY, i ? 32'h0 : 32'h5);
         wr(mac_pkg::OFF_CTRL, RUN | AST | SGL | DLY);
         pulse(2);
         wait_on(2, 100, n);
         chk_rng(n, (ex - 1) * STEP, ex * STEP + 6);
         repeat (10) @(posedge mclk);
         pulse(0);
         wait_on(0, 8, n);
         chk_rng(n, 0, 4);
         wr(mac_pkg::OFF_CTRL, 32'h0);
         repeat (SPACE * STEP) @(posedge mclk);
      end
      // Falling slopes on both arming edges; the source now idles high.
      afall <= 1'b1;
      wr(mac_pkg::OFF_MTIME, 32'd25);
      wr(mac_pkg::OFF_CTRL, RUN | AST | ASP | FAL);
      pulse(2);
      wait_on(2, 20, n);
      pulse(0);
      wait_on(0, 8, n);
      repeat (30) @(posedge mclk);
      pulse(2);
      wait_on(1, 10, n);
      chk_rng(n, 0, 6);
      wr(mac_pkg::OFF_CTRL, 32'h0);
      tally_and_finish;
   end
endmodule
`default_nettype wire

// File: hdl/mac_edge.sv
// Edge detector with selectable slope.
// Assumes its input is synchronous to the clock.
`timescale 1ns/100ps
`default_nettype none
module mac_edge (
   input  wire logic mclk_i,
   input  wire logic rst_n_i,
   input  wire logic sig_i,
   input  wire logic fall_i,
   output logic      edge_o
);
   logic prev_q;

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         prev_q <= 1'b0;
      end else begin
         prev_q <= sig_i;
      end
   end

   assign edge_o = fall_i ? (prev_q & ~sig_i) : (~prev_q & sig_i);
endmodule
`default_nettype wire

// File: hdl/mac_timer.sv
// Loadable down-counter stepping on a shared time-base tick.
// Assumes tick_i is a one-cycle pulse; load wins over a tick.
`timescale 1ns/100ps
`default_nettype none
module mac_timer #(
   parameter int unsigned W = 27
) (
   input  wire logic         mclk_i,
   input  wire logic         rst_n_i,
   input  wire logic         tick_i,
   input  wire logic         load_i,
   input  wire logic [W-1:0] val_i,
   output logic              done_o
);
   logic [W-1:0] cnt_q;

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_q <= '0;
      end else if (load_i) begin
         cnt_q <= val_i;
      end else if (tick_i && cnt_q != '0) begin
         cnt_q <= cnt_q - W'(1);
      end
   end

   assign done_o = (cnt_q == '0);
endmodule
`default_nettype wire

// File: hdl/mac_top.sv
// Measurement start and pacing control with APB registers.
// Assumes arm_i, trig_i and stop_i are synchronous to mclk_i.
//
// Added by the designer: the APB slave port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// [R1] Single mode: measurement ends on stop trigger; measuring time only paces.
// [R2] Single mode hold equals measuring time, at least 3 ms, then waits.
// [R3] Arming edge must lead the start trigger by over 5 ns.
// [R4] Once armed, start on the next measured-input trigger edge.
// [R5] Start arming may be selected on the rising arming edge.
// [R6] Optional delay counted from the arming edge before arming takes effect.
// [R7] Free running: 600 us after the measuring time before the next.
// [R8] Successive starts are at least 500 us apart.
// [R9] Start arming: one measurement per arming edge.
// [R10] Arming delay 200 ns to 1.6 s in 100 ns steps.
// [R11] Stop arming ends the measurement on the selected arming edge.
// [R12] Triggers from 40 ns after delay expiry are always accepted.
// [R13] Without start arming, start on next trigger after the hold ends.
// [R14] Arming edges during measurement or hold are ignored, not queued.
module mac_top #(
   parameter int unsigned HOLD_MIN_ST = mac_pkg::HOLD_MIN_ST,
   parameter int unsigned PROC_ST     = mac_pkg::PROC_ST,
   parameter int unsigned SPACE_ST    = mac_pkg::SPACE_ST,
   parameter int unsigned STEP_CYC    = mac_pkg::STEP_CYC
) (
   input  wire logic                   mclk_i,
   input  wire logic                   rstn_i,
   input  wire logic                   psel_i,
   input  wire logic                   penable_i,
   input  wire logic                   pwrite_i,
   input  wire logic [mac_pkg::AW-1:0] paddr_i,
   input  wire logic [31:0]            pwdata_i,
   output logic [31:0]                 prdata_o,
   output logic                        pready_o,
   output logic                        pslverr_o,
   input  wire logic                   arm_i,
   input  wire logic                   trig_i,
   input  wire logic                   stop_i,
   output logic                        meas_gate_o,
   output logic                        meas_start_o,
   output logic                        meas_end_o,
   output logic                        armed_o
);
   localparam int unsigned TW = mac_pkg::TW;
   localparam logic [TW-1:0] HOLD_MIN_T = TW'(HOLD_MIN_ST);
   localparam logic [TW-1:0] PROC_T     = TW'(PROC_ST);
   localparam logic [TW-1:0] SPACE_T    = TW'(SPACE_ST);
   localparam logic [TW-1:0] DMIN_T     = TW'(mac_pkg::DLY_MIN_ST);
   localparam logic [TW-1:0] DMAX_T     = TW'(mac_pkg::DLY_MAX_ST);
   localparam logic [7:0]    STEP_LAST  = 8'(STEP_CYC - 1);

   logic rst_meta_q, rst_n;
   logic [7:0] pre_q;
   logic tick;
   logic [mac_pkg::CTL_W-1:0] ctrl_q;
   logic [TW-1:0] mtime_q, delay_q, hold_val, tm_val;
   logic [31:0] cnt_q, prdata_q;
   logic missed_q, slverr_q;
   logic run, as_en, ap_en, single, dly_en;
   logic arm_s_edge, arm_p_edge, trig_edge, stop_edge;
   logic tm_load, tm_done, dly_done, sp_done;
   logic start, stop_cond, end_q, start_q, map_ok, wr;
   mac_pkg::mac_state_t st_q, st_d;

   // The external reset is released through two flops to avoid metastability.
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rst_meta_q <= 1'b0;
         rst_n      <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n      <= rst_meta_q;
      end
   end

   // A 100 ns time base keeps every timer narrow at the cost of one step
   // of phase uncertainty on each load.
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         pre_q <= 8'h00;
      end else begin
         pre_q <= (pre_q == STEP_LAST) ? 8'h00 : pre_q + 8'h01;
      end
   end
   assign tick = (pre_q == STEP_LAST);

   assign run    = ctrl_q[mac_pkg::CTL_RUN];
   assign as_en  = ctrl_q[mac_pkg::CTL_ASTART];
   assign ap_en  = ctrl_q[mac_pkg::CTL_ASTOP];
   assign single = ctrl_q[mac_pkg::CTL_SINGLE];
   assign dly_en = ctrl_q[mac_pkg::CTL_DLY_EN];

   mac_edge u_arm_start (
      .mclk_i  (mclk_i),
      .rst_n_i (rst_n),
      .sig_i   (arm_i),
      .fall_i  (ctrl_q[mac_pkg::CTL_AS_FAL]),
      .edge_o  (arm_s_edge)
   );
   mac_edge u_arm_stop (
      .mclk_i  (mclk_i),
      .rst_n_i (rst_n),
      .sig_i   (arm_i),
      .fall_i  (ctrl_q[mac_pkg::CTL_AP_FAL]),
      .edge_o  (arm_p_edge)
   );
   mac_edge u_trig (
      .mclk_i  (mclk_i),
      .rst_n_i (rst_n),
      .sig_i   (trig_i),
      .fall_i  (1'b0),
      .edge_o  (trig_edge)
   );
   mac_edge u_stop (
      .mclk_i  (mclk_i),
      .rst_n_i (rst_n),
      .sig_i   (stop_i),
      .fall_i  (1'b0),
      .edge_o  (stop_edge)
   );

   // Single mode holds for the measuring time, never under the minimum.
   assign hold_val = single ? ((mtime_q > HOLD_MIN_T) ? mtime_q : HOLD_MIN_T)
                            : PROC_T; // see [R1] see [R2] see [R7]
   assign tm_load  = (st_d != st_q) &&
                     (st_d == mac_pkg::MAC_MEAS || st_d == mac_pkg::MAC_HOLD);
   assign tm_val   = (st_d == mac_pkg::MAC_MEAS) ? mtime_q : hold_val;

   mac_timer #(.W(TW)) u_tm (
      .mclk_i  (mclk_i),
      .rst_n_i (rst_n),
      .tick_i  (tick),
      .load_i  (tm_load),
      .val_i   (tm_val),
      .done_o  (tm_done)
   );
   mac_timer #(.W(TW)) u_dly (
      .mclk_i  (mclk_i),
      .rst_n_i (rst_n),
      .tick_i  (tick),
      .load_i  (st_d == mac_pkg::MAC_DELAY && st_q != mac_pkg::MAC_DELAY),
      .val_i   (delay_q),
      .done_o  (dly_done)
   );
   mac_timer #(.W(TW)) u_space (
      .mclk_i  (mclk_i),
      .rst_n_i (rst_n),
      .tick_i  (tick),
      .load_i  (start),
      .val_i   (SPACE_T),
      .done_o  (sp_done)
   );

   assign stop_cond = ap_en ? arm_p_edge : (single ? stop_edge : tm_done);

   always_comb begin
      st_d  = st_q;
      start = 1'b0;
      if (!run) begin
         st_d = mac_pkg::MAC_IDLE;
      end else begin
         case (st_q)
            mac_pkg::MAC_IDLE: begin
               if (!as_en) begin
                  st_d = mac_pkg::MAC_WAIT; // see [R13]
               end else if (arm_s_edge) begin
                  st_d = dly_en ? mac_pkg::MAC_DELAY
                                : mac_pkg::MAC_WAIT; // see [R5] see [R9]
               end
            end
            mac_pkg::MAC_DELAY: begin
               if (dly_done) begin
                  st_d = mac_pkg::MAC_WAIT; // see [R6] see [R12]
               end
            end
            mac_pkg::MAC_WAIT: begin
               if (trig_edge && sp_done) begin
                  st_d  = mac_pkg::MAC_MEAS; // see [R4] see [R8]
                  start = 1'b1;
               end
            end
            mac_pkg::MAC_MEAS: begin
               if (stop_cond) begin
                  st_d = mac_pkg::MAC_HOLD; // see [R11] see [R1]
               end
            end
            mac_pkg::MAC_HOLD: begin
               if (tm_done) begin
                  st_d = as_en ? mac_pkg::MAC_IDLE
                               : mac_pkg::MAC_WAIT; // see [R14]
               end
            end
            default: st_d = mac_pkg::MAC_IDLE;
         endcase
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         st_q    <= mac_pkg::MAC_IDLE;
         start_q <= 1'b0;
         end_q   <= 1'b0;
      end else begin
         st_q    <= st_d;
         start_q <= start;
         end_q   <= (st_q == mac_pkg::MAC_MEAS) && (st_d == mac_pkg::MAC_HOLD);
      end
   end

   assign meas_gate_o  = (st_q == mac_pkg::MAC_MEAS);
   assign meas_start_o = start_q;
   assign meas_end_o   = end_q;
   assign armed_o      = (st_q == mac_pkg::MAC_WAIT);

   // APB: data is latched in the setup cycle, so every access is zero-wait.
   assign map_ok = (paddr_i == mac_pkg::OFF_CTRL)  ||
                   (paddr_i == mac_pkg::OFF_MTIME) ||
                   (paddr_i == mac_pkg::OFF_DELAY) ||
                   (paddr_i == mac_pkg::OFF_STATUS) ||
                   (paddr_i == mac_pkg::OFF_COUNT);
   assign wr = psel_i && penable_i && pwrite_i && map_ok;

   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         prdata_q <= 32'h00000000;
         slverr_q <= 1'b0;
      end else if (psel_i && !penable_i) begin
         slverr_q <= !map_ok;
         case (paddr_i)
            mac_pkg::OFF_CTRL:   prdata_q <= 32'(ctrl_q);
            mac_pkg::OFF_MTIME:  prdata_q <= 32'(mtime_q);
            mac_pkg::OFF_DELAY:  prdata_q <= 32'(delay_q);
            mac_pkg::OFF_STATUS: prdata_q <= {28'h0000000, missed_q, st_q};
            mac_pkg::OFF_COUNT:  prdata_q <= cnt_q;
            default:             prdata_q <= 32'h00000000;
         endcase
      end
   end
   assign prdata_o  = prdata_q;
   assign pslverr_o = slverr_q;
   assign pready_o  = 1'b1;

   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q  <= mac_pkg::CTRL_RST;
         mtime_q <= mac_pkg::MTIME_RST;
         delay_q <= mac_pkg::DELAY_RST;
      end else if (wr) begin
         if (paddr_i == mac_pkg::OFF_CTRL) begin
            ctrl_q <= pwdata_i[mac_pkg::CTL_W-1:0];
         end
         if (paddr_i == mac_pkg::OFF_MTIME) begin
            mtime_q <= pwdata_i[TW-1:0];
         end
         // Out-of-range delays are clamped rather than refused.
         if (paddr_i == mac_pkg::OFF_DELAY) begin
            delay_q <= (pwdata_i[TW-1:0] < DMIN_T) ? DMIN_T :
                       (pwdata_i[TW-1:0] > DMAX_T) ? DMAX_T :
                       pwdata_i[TW-1:0]; // see [R10]
         end
      end
   end

   // A refused arming edge is flagged; a new one beats a clear.
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         missed_q <= 1'b0;
      end else begin
         missed_q <= (as_en && arm_s_edge && st_q != mac_pkg::MAC_IDLE) ||
                     (missed_q && !(wr && paddr_i == mac_pkg::OFF_STATUS &&
                      pwdata_i[mac_pkg::STS_MISSED])); // see [R14]
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= 32'h00000000;
      end else if (start) begin
         cnt_q <= cnt_q + 32'h00000001;
      end
   end

   logic [TW-1:0] hold_tk_q, gap_tk_q;
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         hold_tk_q <= '0;
         gap_tk_q  <= '1;
      end else begin
         hold_tk_q <= (st_q != mac_pkg::MAC_HOLD) ? '0 :
                      hold_tk_q + TW'(tick);
         gap_tk_q  <= start ? '0 :
                      (gap_tk_q == '1) ? gap_tk_q : gap_tk_q + TW'(tick);
      end
   end

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_n);

   property p_start_on_trig;
      meas_start_o |-> $past(trig_edge) && $past(st_q) == mac_pkg::MAC_WAIT;
   endproperty
   a_start_on_trig: assert property (p_start_on_trig) // see [R4]
      else $error("start not caused by trigger edge");
   property p_single_stop;
      (st_q == mac_pkg::MAC_MEAS && run && single && !ap_en && stop_edge)
         |=> st_q == mac_pkg::MAC_HOLD && meas_end_o ##1 !meas_end_o;
   endproperty
   a_single_stop: assert property (p_single_stop) // see [R1]
      else $error("single measurement did not end on stop trigger");
   property p_single_hold;
      (st_q == mac_pkg::MAC_HOLD && st_d != st_q && run && single)
         |-> hold_tk_q >= HOLD_MIN_T && hold_tk_q >= mtime_q;
   endproperty
   a_single_hold: assert property (p_single_hold) // see [R2]
      else $error("single hold shorter than required");
   property p_free_hold;
      (st_q == mac_pkg::MAC_HOLD && st_d != st_q && run && !single)
         |-> hold_tk_q >= PROC_T;
   endproperty
   a_free_hold: assert property (p_free_hold) // see [R7]
      else $error("processing gap too short");
   property p_spacing;
      start |-> gap_tk_q >= SPACE_T;
   endproperty
   a_spacing: assert property (p_spacing) // see [R8]
      else $error("starts closer than minimum spacing");
   property p_arm_rise;
      (st_q == mac_pkg::MAC_IDLE && run && as_en && !dly_en &&
       !ctrl_q[mac_pkg::CTL_AS_FAL] && arm_i && !$past(arm_i))
         |=> armed_o;
   endproperty
   a_arm_rise: assert property (p_arm_rise) // see [R5]
      else $error("rising arming edge did not arm");
   property p_delay_hold;
      (st_q == mac_pkg::MAC_DELAY && run && !dly_done)
         |=> st_q == mac_pkg::MAC_DELAY;
   endproperty
   a_delay_hold: assert property (p_delay_hold) // see [R6]
      else $error("armed before delay expiry");
   property p_stop_arm;
      (st_q == mac_pkg::MAC_MEAS && run && ap_en && !arm_p_edge)
         |=> st_q == mac_pkg::MAC_MEAS;
   endproperty
   a_stop_arm: assert property (p_stop_arm) // see [R11]
      else $error("measurement ended without stop arming edge");
   property p_no_queue;
      (st_q == mac_pkg::MAC_HOLD && arm_s_edge)
         |=> st_q != mac_pkg::MAC_DELAY && !(as_en && armed_o);
   endproperty
   a_no_queue: assert property (p_no_queue) // see [R14] see [R9]
      else $error("arming edge in hold was queued");
   property p_free_rearm;
      (st_q == mac_pkg::MAC_HOLD && tm_done && run && !as_en) |=> armed_o;
   endproperty
   a_free_rearm: assert property (p_free_rearm) // see [R13]
      else $error("free run did not wait for trigger after hold");
   property p_delay_range;
      delay_q >= DMIN_T && delay_q <= DMAX_T;
   endproperty
   a_delay_range: assert property (p_delay_range) // see [R10]
      else $error("arming delay out of range");

   c_single: cover property (meas_start_o ##[1:1000] meas_end_o);
   c_delay: cover property (st_q == mac_pkg::MAC_DELAY ##1 armed_o);
   c_stop_arm: cover property (meas_gate_o && ap_en ##1 meas_end_o);
   c_missed: cover property (!missed_q ##1 missed_q);
endmodule
`default_nettype wire

// File: shared/mac_pkg.sv
// Constants, register map and state type of the measurement arming control.
// Assumes a 250 MHz clock and a 32-bit APB register port.
`default_nettype none
package mac_pkg;
   localparam int unsigned CLK_NS      = 4;
   localparam int unsigned STEP_NS     = 100;
   localparam int unsigned STEP_CYC    = STEP_NS / CLK_NS;
   localparam int unsigned HOLD_MIN_NS = 3_000_000;
   localparam int unsigned PROC_NS     = 600_000;
   localparam int unsigned SPACE_NS    = 500_000;
   localparam int unsigned DLY_MIN_NS  = 200;
   localparam int unsigned DLY_MAX_NS  = 1_600_000_000;
   localparam int unsigned HOLD_MIN_ST = (HOLD_MIN_NS + STEP_NS - 1) / STEP_NS;
   localparam int unsigned PROC_ST     = (PROC_NS + STEP_NS - 1) / STEP_NS;
   localparam int unsigned SPACE_ST    = (SPACE_NS + STEP_NS - 1) / STEP_NS;
   localparam int unsigned DLY_MIN_ST  = (DLY_MIN_NS + STEP_NS - 1) / STEP_NS;
   localparam int unsigned DLY_MAX_ST  = DLY_MAX_NS / STEP_NS;
   localparam int unsigned TW          = 27;
   localparam int unsigned AW          = 8;
   localparam logic [AW-1:0] OFF_CTRL   = 8'h00;
   localparam logic [AW-1:0] OFF_MTIME  = 8'h04;
   localparam logic [AW-1:0] OFF_DELAY  = 8'h08;
   localparam logic [AW-1:0] OFF_STATUS = 8'h0c;
   localparam logic [AW-1:0] OFF_COUNT  = 8'h10;
   localparam int unsigned CTL_RUN    = 0;
   localparam int unsigned CTL_ASTART = 1;
   localparam int unsigned CTL_AS_FAL = 2;
   localparam int unsigned CTL_ASTOP  = 3;
   localparam int unsigned CTL_AP_FAL = 4;
   localparam int unsigned CTL_SINGLE = 5;
   localparam int unsigned CTL_DLY_EN = 6;
   localparam int unsigned CTL_W      = 7;
   localparam int unsigned STS_MISSED = 3;
   localparam logic [CTL_W-1:0] CTRL_RST  = 7'h00;
   localparam logic [TW-1:0]    MTIME_RST = 27'h0002710;
   localparam logic [TW-1:0]    DELAY_RST = 27'h0000002;
   typedef enum logic [2:0] {
      MAC_IDLE, MAC_DELAY, MAC_WAIT, MAC_MEAS, MAC_HOLD
   } mac_state_t;
endpackage
`default_nettype wire
